// ===== cop_clock_output_path.sv
// Configuration and output gating of a four-output clock conditioner
// How it works
// R1: Divider only acts in divided path modes
// R2: Host pulses alignment pin after programming dividers
// R3: Divide code gives ratio twice its value
// R4: Output divider follows the shared VCO divider
// R5: Divider path adds about 100 ps
// R6: Delay only acts in delayed path modes
// R7: Delay code adds 150 ps per step
// R8: Delay path adds fixed 400 ps
// R9: Per-output enable bit, default disabled
// R10: Global enable or gate pin low kills outputs
// R11: Drive needs own, global enable, gate high
// R12: Prescale bit divides lock detect by four
// R13: Host writes prescale only above 20 MHz
// R14: Host writes fixed bits of global register
// R15: Reference divider is plain binary, default ten
// R16: Lock pin codes zero to four
// R17: Analog lock codes and feedback halved
// R18: Code eleven is reference halved; others invalid
// R19: Shutdown bit stops everything; here lockDetectClock keeps running during shutdown
// R20: Path select bypass, divided, delayed, both
// R21: Fields change only when word is latched
`timescale 1ns/1ps
`default_nettype none
module cop_clock_output_path #(
    parameter int NUM_OUT = cop_pkg::NUM_OUTPUTS
) (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    serialClockPin,
    input  wire logic                    serialDataPin,
    input  wire logic                    serialLatchPin,
    input  wire logic                    outputGatePin,
    input  wire logic                    vcoDivClock,
    input  wire logic                    lockDetectRaw,
    input  wire logic                    analogLockRaw,
    input  wire logic                    feedbackDivClock,
    input  wire logic                    refDivClock,
    output var  logic [NUM_OUT-1:0]      clockOut,
    output var  logic [NUM_OUT-1:0]      clockOutEnable,
    output var  logic [NUM_OUT*4-1:0]    outputDelayCode,
    output var  logic [NUM_OUT*2-1:0]    outputPathSelect,
    output var  logic [11:0]             refDivide,
    output var  logic                    lockDetectPrescale,
    output var  logic                    lockDetectClock,
    output var  logic                    fullShutdown,
    output var  logic                    lockIndicatorOut,
    output var  logic                    lockIndicatorOe
);
    import cop_pkg::*;

    typedef struct packed {
        cop_serial_type                     sync1;
        cop_serial_type                     sync2;
        cop_serial_type                     prev;
        logic [WORD_BITS-1:0]               shiftWord;
        cop_out_cfg_type [NUM_OUT-1:0]      outCfg;
        cop_glob_cfg_type                   globCfg;
        logic [1:0]                         gateSync;
        logic [4:0]                         clkSync1;
        logic [4:0]                         clkSync2;
        logic [1:0]                         prescaleCount;
        logic                               prevDldClk;
        logic                               nHalf;
        logic                               rHalf;
        logic                               prevFb;
        logic                               prevRef;
        logic                               prevVco;
        logic [NUM_OUT-1:0]                 outLevel;
    } cop_state_type;

    cop_state_type state_reg;
    cop_state_type state_next;

    function automatic cop_state_type reset_state();
        cop_state_type s;
        s = '0;
        for (int i = 0; i < NUM_OUT; i++) begin
            s.outCfg[i].outputPathSelect = PATH_BYPASS;
            s.outCfg[i].outputEnableBit  = 1'b0;          // R9
            s.outCfg[i].outputDivideCode = DIV_DEFAULT;
            s.outCfg[i].outputDelayCode  = DLY_DEFAULT;
        end
        s.globCfg.allOutputsEnable   = 1'b1;
        s.globCfg.fullShutdownBit    = 1'b0;
        s.globCfg.lockPinSelect      = LOCK_SEL_DEFAULT;
        s.globCfg.refDivide          = REF_DIV_DEFAULT;  // R15
        s.globCfg.lockDetectPrescale = 1'b0;
        return s;
    endfunction : reset_state

    // Constant reset image, so the asynchronous reset loads no logic
    localparam cop_state_type RESET_STATE = reset_state();

    // ==========================================================
    // Per-output dividers on the synchronised VCO divider clock
    logic [NUM_OUT-1:0] divRun;
    logic [NUM_OUT-1:0] divClk;
    logic [NUM_OUT-1:0] outDrive;
    logic               gateOpen;
    logic               vcoSampled;
    logic               vcoRise;

    assign vcoSampled = state_reg.clkSync2[0];
    assign vcoRise    = state_reg.clkSync2[0] && !state_reg.prevVco;          // R4
    // Gate pin has an internal pull-up, so an open pin counts as high
    assign gateOpen = state_reg.globCfg.allOutputsEnable && state_reg.gateSync[1]
        && !state_reg.globCfg.fullShutdownBit;                                  // R10 R19

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : gen_out
            assign divRun[g] = !state_reg.globCfg.fullShutdownBit &&
                (state_reg.outCfg[g].outputPathSelect == PATH_DIVIDED ||
                 state_reg.outCfg[g].outputPathSelect == PATH_DIV_DLY);      // R1 R20
            // Divider counts edges of the shared VCO divider output
            cop_divider u_div (                                              // R4
                .clock      (clock),
                .nrst       (nrst),
                .run        (divRun[g]),
                .vcoEdge    (vcoRise),
                .divideCode (state_reg.outCfg[g].outputDivideCode),
                .divOut     (divClk[g])
            );
            assign outDrive[g] = state_reg.outCfg[g].outputEnableBit && gateOpen; // R11
            // Analog delays are not modelled; code and mode go to the delay line
            assign clockOutEnable[g] = outDrive[g];                           // R9 R10
            // Only delayed modes pass the code, so other modes see zero delay
            assign outputDelayCode[g*4 +: 4] =
                (state_reg.outCfg[g].outputPathSelect == PATH_DELAYED ||
                 state_reg.outCfg[g].outputPathSelect == PATH_DIV_DLY)
                ? state_reg.outCfg[g].outputDelayCode : 4'h0;                 // R6 R7 R8
            assign outputPathSelect[g*2 +: 2] = state_reg.outCfg[g].outputPathSelect;
        end
    endgenerate

    // ==========================================================
    // Serial shift register and word latch
    logic       risingSclk;
    logic       risingLatch;
    logic [3:0] wordAddr;
    logic       dldEdge;
    logic       fbEdge;
    logic       refEdge;

    always_comb begin
        state_next = state_reg;
        risingSclk  = state_reg.sync2.serialClock && !state_reg.prev.serialClock;
        risingLatch = state_reg.sync2.serialLatch && !state_reg.prev.serialLatch;
        wordAddr    = state_reg.shiftWord[3:0];
        state_next.sync1 = '{serialClock: serialClockPin, serialData: serialDataPin,
                             serialLatch: serialLatchPin};
        state_next.sync2 = state_reg.sync1;
        state_next.prev  = state_reg.sync2;
        state_next.gateSync = {state_reg.gateSync[0], outputGatePin};
        state_next.clkSync1 = {analogLockRaw, refDivClock, feedbackDivClock, lockDetectRaw,
                               vcoDivClock};
        state_next.prevVco  = state_reg.clkSync2[0];
        state_next.clkSync2 = state_reg.clkSync1;
        if (risingSclk) begin
            state_next.shiftWord = {state_reg.shiftWord[WORD_BITS-2:0],
                                    state_reg.sync2.serialData};
        end
        if (risingLatch) begin                                                // R21
            if (wordAddr == ADDR_RESET_REG && state_reg.shiftWord[RESET_BIT_POS]) begin
                state_next.outCfg  = RESET_STATE.outCfg;
                state_next.globCfg = RESET_STATE.globCfg;
            end else if (wordAddr >= ADDR_RESET_REG && wordAddr <= ADDR_OUT3_REG &&
                         (wordAddr >= ADDR_OUT0_REG || wordAddr == ADDR_RESET_REG)) begin
                for (int i = 0; i < NUM_OUT; i++) begin
                    if (wordAddr == ADDR_OUT0_REG + 4'(i) ||
                        (i == 0 && wordAddr == ADDR_RESET_REG)) begin
                        state_next.outCfg[i].outputPathSelect =
                            cop_path_type'(state_reg.shiftWord[PATH_SEL_LSB +: 2]);
                        state_next.outCfg[i].outputEnableBit  = state_reg.shiftWord[OUT_EN_POS];
                        state_next.outCfg[i].outputDivideCode = state_reg.shiftWord[DIV_LSB +: 8];
                        state_next.outCfg[i].outputDelayCode  = state_reg.shiftWord[DLY_LSB +: 4];
                    end
                end
            end else if (wordAddr == ADDR_PRESCALE_REG) begin
                state_next.globCfg.lockDetectPrescale = state_reg.shiftWord[PRESCALE_POS];
            end else if (wordAddr == ADDR_GLOBAL_REG) begin
                state_next.globCfg.allOutputsEnable = state_reg.shiftWord[GLOBAL_EN_POS];
                state_next.globCfg.fullShutdownBit  = state_reg.shiftWord[SHUTDOWN_POS];
                state_next.globCfg.lockPinSelect    = state_reg.shiftWord[LOCK_SEL_LSB +: 4];
                state_next.globCfg.refDivide        = state_reg.shiftWord[REF_DIV_LSB +: 12];
            end
        end
        // Lock detect prescaler: one output edge every four input edges
        dldEdge = state_reg.clkSync2[1] && !state_reg.prevDldClk;
        state_next.prevDldClk = state_reg.clkSync2[1];
        if (dldEdge) begin
            state_next.prescaleCount = state_reg.prescaleCount + 2'h1;        // R12
        end
        // Halved feedback and reference dividers for the lock pin
        fbEdge  = state_reg.clkSync2[2] && !state_reg.prevFb;
        refEdge = state_reg.clkSync2[3] && !state_reg.prevRef;
        state_next.prevFb  = state_reg.clkSync2[2];
        state_next.prevRef = state_reg.clkSync2[3];
        if (fbEdge) begin
            state_next.nHalf = ~state_reg.nHalf;                              // R17
        end
        if (refEdge) begin
            state_next.rHalf = ~state_reg.rHalf;                              // R18
        end
        // Output level is registered so the pin never sees a decode glitch
        for (int i = 0; i < NUM_OUT; i++) begin
            state_next.outLevel[i] = outDrive[i] && (divRun[i] ? divClk[i] : vcoSampled); // R5
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Configuration outputs
    assign clockOut           = state_reg.outLevel;                           // R11
    assign refDivide          = state_reg.globCfg.refDivide;                  // R15
    assign lockDetectPrescale = state_reg.globCfg.lockDetectPrescale;
    assign fullShutdown       = state_reg.globCfg.fullShutdownBit;            // R19
    assign lockDetectClock    = state_reg.globCfg.lockDetectPrescale
        ? state_reg.prescaleCount[1] : state_reg.clkSync2[1];                 // R12

    // ==========================================================
    // Lock indicator pin; open-drain modes drive only one level
    always_comb begin
        lockIndicatorOut = 1'b0;
        lockIndicatorOe  = 1'b0;
        if (!state_reg.globCfg.fullShutdownBit) begin                         // R19
            case (state_reg.globCfg.lockPinSelect)                            // R16
                LOCK_HIGH: begin
                    lockIndicatorOut = 1'b1;
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_LOW: begin
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_DLD_HI: begin
                    lockIndicatorOut = state_reg.clkSync2[1];
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_DLD_LO: begin
                    lockIndicatorOut = !state_reg.clkSync2[1];
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_ALD_PP: begin                                            // R17
                    lockIndicatorOut = state_reg.clkSync2[4];
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_ALD_NOD: begin
                    lockIndicatorOe  = !state_reg.clkSync2[4];
                end
                LOCK_ALD_POD: begin
                    lockIndicatorOut = 1'b1;
                    lockIndicatorOe  = state_reg.clkSync2[4];
                end
                LOCK_NDIV2: begin
                    lockIndicatorOut = state_reg.nHalf;
                    lockIndicatorOe  = 1'b1;
                end
                LOCK_RDIV2: begin                                             // R18
                    lockIndicatorOut = state_reg.rHalf;
                    lockIndicatorOe  = 1'b1;
                end
                // Invalid codes float the pin
                default: begin
                    lockIndicatorOut = 1'b0;
                    lockIndicatorOe  = 1'b0;
                end
            endcase
        end
    end

    AST_GATE_KILLS: assert property (@(posedge clock) disable iff (!nrst) // R10
        (!state_reg.globCfg.allOutputsEnable || !state_reg.gateSync[1])
            |-> clockOutEnable == '0)
        else $error("output enabled while gated");
    AST_SHUTDOWN_PIN: assert property (@(posedge clock) disable iff (!nrst) // R19
        fullShutdown |-> !lockIndicatorOe && clockOutEnable == '0)
        else $error("activity during shutdown");
    AST_CFG_HOLD: assert property (@(posedge clock) disable iff (!nrst) // R21
        !$past(risingLatch) |-> $stable(state_reg.globCfg))
        else $error("config changed without latch");
    AST_DELAY_MASK: assert property (@(posedge clock) disable iff (!nrst) // R6
        (outputPathSelect[1:0] inside {2'h0, 2'h1}) |-> outputDelayCode[3:0] == 4'h0)
        else $error("delay code leaked in undelayed mode");
    AST_OUT_LOW: assert property (@(posedge clock) disable iff (!nrst) // R11
        !$past(outDrive[0]) |-> !clockOut[0])
        else $error("disabled output toggled");
    AST_LOCK_HIGH: assert property (@(posedge clock) disable iff (!nrst) // R16
        (state_reg.globCfg.lockPinSelect == LOCK_HIGH && !fullShutdown)
            |-> lockIndicatorOe && lockIndicatorOut)
        else $error("lock pin not high");
    AST_LOCK_HIZ: assert property (@(posedge clock) disable iff (!nrst) // R18
        (state_reg.globCfg.lockPinSelect inside {4'h0, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF})
            |-> !lockIndicatorOe)
        else $error("lock pin driven on invalid code");
    AST_DIV_IDLE: assert property (@(posedge clock) disable iff (!nrst) // R1
        (!divRun[0] && $past(!divRun[0])) |-> !divClk[0])
        else $error("divider ran in bypass mode");

endmodule : cop_clock_output_path
`default_nettype wire

// ===== cop_pkg.sv
// Package of register layouts, field positions and defaults for the clock output path block
package cop_pkg;

    // ==========================================================
    // Register addresses (low four bits of the serial word)
    localparam logic [3:0] ADDR_RESET_REG   = 4'h0;
    localparam logic [3:0] ADDR_OUT0_REG    = 4'h4;
    localparam logic [3:0] ADDR_OUT3_REG    = 4'h7;
    localparam logic [3:0] ADDR_PRESCALE_REG = 4'hB;
    localparam logic [3:0] ADDR_GLOBAL_REG  = 4'hE;

    // ==========================================================
    // Field positions
    localparam int RESET_BIT_POS   = 31;
    localparam int PATH_SEL_LSB    = 17;
    localparam int OUT_EN_POS      = 16;
    localparam int DIV_LSB         = 8;
    localparam int DLY_LSB         = 4;
    localparam int PRESCALE_POS    = 15;
    localparam int GLOBAL_EN_POS   = 27;
    localparam int SHUTDOWN_POS    = 26;
    localparam int LOCK_SEL_LSB    = 20;
    localparam int REF_DIV_LSB     = 8;
    localparam int WORD_BITS       = 32;
    localparam int NUM_OUTPUTS     = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  DIV_DEFAULT     = 8'h01;
    localparam logic [3:0]  DLY_DEFAULT     = 4'h0;
    localparam logic [11:0] REF_DIV_DEFAULT = 12'h00A;
    localparam logic [3:0]  LOCK_SEL_DEFAULT = 4'h0;

    // ==========================================================
    // Delay figures in picoseconds, and the lock detect prescale factor
    localparam int DLY_STEP_PS      = 150;
    localparam int DLY_FIXED_PS     = 400;
    localparam int DIV_FIXED_PS     = 100;
    localparam int PRESCALE_FACTOR  = 4;

    // ==========================================================
    // Path select modes
    typedef enum logic [1:0] {
        PATH_BYPASS  = 2'h0,
        PATH_DIVIDED = 2'h1,
        PATH_DELAYED = 2'h2,
        PATH_DIV_DLY = 2'h3
    } cop_path_type;

    // Lock pin select codes
    localparam logic [3:0] LOCK_HIZ     = 4'h0;
    localparam logic [3:0] LOCK_HIGH    = 4'h1;
    localparam logic [3:0] LOCK_LOW     = 4'h2;
    localparam logic [3:0] LOCK_DLD_HI  = 4'h3;
    localparam logic [3:0] LOCK_DLD_LO  = 4'h4;
    localparam logic [3:0] LOCK_ALD_PP  = 4'h5;
    localparam logic [3:0] LOCK_ALD_NOD = 4'h6;
    localparam logic [3:0] LOCK_ALD_POD = 4'h7;
    localparam logic [3:0] LOCK_NDIV2   = 4'h9;
    localparam logic [3:0] LOCK_RDIV2   = 4'hB;

    // Per-output settings
    typedef struct packed {
        cop_path_type outputPathSelect;
        logic         outputEnableBit;
        logic [7:0]   outputDivideCode;
        logic [3:0]   outputDelayCode;
    } cop_out_cfg_type;

    // Global settings
    typedef struct packed {
        logic        allOutputsEnable;
        logic        fullShutdownBit;
        logic [3:0]  lockPinSelect;
        logic [11:0] refDivide;
        logic        lockDetectPrescale;
    } cop_glob_cfg_type;

    // Serial link pins after synchronisation
    typedef struct packed {
        logic serialClock;
        logic serialData;
        logic serialLatch;
    } cop_serial_type;

endpackage : cop_pkg

// ===== cop_divider.sv
// Even-ratio divider for one clock output
`timescale 1ns/1ps
`default_nettype none
module cop_divider (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic       vcoEdge,
    input  wire logic [7:0] divideCode,
    output var  logic       divOut
);
    import cop_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic       level;
    } cop_div_state_type;

    cop_div_state_type state_reg;
    cop_div_state_type state_next;

    // ==========================================================
    // Toggle every code VCO divider edges: ratio is twice the code
    always_comb begin
        state_next = state_reg;
        if (!run || divideCode == 8'h00) begin
            state_next.count = 8'h00;
            state_next.level = 1'b0;
        end else if (vcoEdge) begin                                          // R4
            if (state_reg.count + 8'h01 >= divideCode) begin                 // R3
                state_next.count = 8'h00;
                state_next.level = ~state_reg.level;
            end else begin
                state_next.count = state_reg.count + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign divOut = state_reg.level;

    AST_DIV_HALF_PERIOD: assert property (@(posedge clock) disable iff (!nrst) // R3
        (run && divideCode == 8'h01 && vcoEdge) |=> (divOut != $past(divOut)))
        else $error("divide by two output did not toggle");
    AST_DIV_HOLD: assert property (@(posedge clock) disable iff (!nrst) // R4
        (run && divideCode != 8'h00 && !vcoEdge) |=> $stable(divOut))
        else $error("divider moved without a VCO edge");

endmodule : cop_divider
`default_nettype wire

// ===== cop_host_model.sv
// Host model driving the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module cop_host_model (
    input  wire logic clock,
    output var  logic serialClockPin,
    output var  logic serialDataPin,
    output var  logic serialLatchPin,
    output var  logic nAlign
);
    import cop_pkg::*;
    // ==========================================================
    // Each pin level is held 4 cycles, one above the synchroniser need
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : hold
    task automatic send(input logic [31:0] w, input int nBits);
        for (int b = nBits - 1; b >= 0; b--) begin
            serialDataPin = w[b];
            hold(4);
            serialClockPin = 1'b1;
            hold(4);
            serialClockPin = 1'b0;
        end
        // Released data shows the inverse so a stale bit is never taken for a new one
        serialDataPin = ~w[0];
    endtask : send
    task automatic latch();
        serialLatchPin = 1'b1;
        hold(4);
        serialLatchPin = 1'b0;
        hold(8);
    endtask : latch
    task automatic align();
        nAlign = 1'b0;
        hold(4);
        nAlign = 1'b1;
        hold(4);
    endtask : align
    initial begin
        serialClockPin = 1'b0;
        serialDataPin  = 1'b0;
        serialLatchPin = 1'b0;
        nAlign         = 1'b1;
    end
endmodule : cop_host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the clock output path block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
    $display("wrong value %s expected %0h seen %0h", n, e, g); fails++; end end
module tb_top;
    import cop_pkg::*;
    logic        clock, nrst, gate, vco, ldRaw, alRaw, sClk, sDat, sLat, prev, nAlign;
    logic [3:0]  ckOut, ckOe;
    logic [15:0] dlyCode;
    logic [7:0]  pathSel;
    logic [11:0] refDiv;
    logic        presc, ldClk, shut, lockOut, lockOe;
    int          fails, samplesChecked, p, cnt;
    typedef struct packed {logic [1:0] i; logic [1:0] p; logic e; logic [3:0] y;} cop_row_type;
    cop_row_type rows [6] = '{'{2'h0, 2'h0, 1'h1, 4'h5}, '{2'h1, 2'h1, 1'h1, 4'h7},
        '{2'h2, 2'h2, 1'h0, 4'h9}, '{2'h3, 2'h3, 1'h1, 4'hF},
        '{2'h0, 2'h2, 1'h1, 4'h0}, '{2'h3, 2'h0, 1'h0, 4'hF}};
    // Lock pin rows: code, drive enable, value checked, value
    logic [6:0]  lk [10] = '{7'h00, 7'h0F, 7'h16, 7'h1F, 7'h26, 7'h2F, 7'h30, 7'h3F, 7'h4C,
        7'h5C};
    cop_clock_output_path i_cop_clock_output_path (.clock(clock), .nrst(nrst),
        .serialClockPin(sClk), .serialDataPin(sDat), .serialLatchPin(sLat),
        .outputGatePin(gate), .vcoDivClock(vco), .lockDetectRaw(ldRaw),
        .analogLockRaw(alRaw), .feedbackDivClock(vco), .refDivClock(vco),
        .clockOut(ckOut), .clockOutEnable(ckOe), .outputDelayCode(dlyCode),
        .outputPathSelect(pathSel), .refDivide(refDiv), .lockDetectPrescale(presc),
        .lockDetectClock(ldClk), .fullShutdown(shut), .lockIndicatorOut(lockOut),
        .lockIndicatorOe(lockOe));
    cop_host_model i_cop_host_model (.clock(clock), .serialClockPin(sClk),
        .serialDataPin(sDat), .serialLatchPin(sLat), .nAlign(nAlign));
    // ==========================================================
    // Word builders and helpers
    function automatic logic [31:0] outWord(input logic [1:0] i, input logic [1:0] q,
        input logic e, input logic [7:0] d, input logic [3:0] y);
        return {13'h0000, q, e, d, y, 2'h1, i};
    endfunction : outWord
    function automatic logic [31:0] globWord(input logic e, input logic s,
        input logic [3:0] m, input logic [11:0] r);
        return {4'h2, e, s, 2'h0, m, r, 4'h0, ADDR_GLOBAL_REG};
    endfunction : globWord
    function automatic logic [31:0] prescWord(input logic d);
        return {8'h00, 1'h1, 5'h00, 2'h2, d, 11'h000, ADDR_PRESCALE_REG};
    endfunction : prescWord
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic put(input logic [31:0] w);
        i_cop_host_model.send(w, 32);
        i_cop_host_model.latch();
    endtask : put
    task automatic waitOut(input int i, input logic v, inout int n);
        int b;
        b = 0;
        while (ckOut[i] !== v) begin
            @(posedge clock);
            #1;
            n++;
            b++;
            if (b > 3000) begin
                fails++;
                conclude();
            end
        end
    endtask : waitOut
    task automatic period(input int i, output int n);
        n = 0;
        waitOut(i, 1'b0, n);
        waitOut(i, 1'b1, n);
        n = 0;
        waitOut(i, 1'b0, n);
        waitOut(i, 1'b1, n);
    endtask : period
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always begin
        repeat (4) @(posedge clock);
        #1 vco = ~vco;
    end
    // ==========================================================
    // Main sequence
    initial begin
        nrst = 1'b0; gate = 1'b1; vco = 1'b0; ldRaw = 1'b1; alRaw = 1'b1;
        fails = 0; samplesChecked = 0;
        repeat (6) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        `CHK("enable", 4'h0, ckOe)
        `CHK("refDiv", 12'h00A, refDiv)
        `CHK("presc", 1'b0, presc)
        `CHK("shutdown", 1'b0, shut)
        `CHK("lockOe", 1'b0, lockOe)
        `CHK("path", 8'h00, pathSel)
        `CHK("delay", 16'h0000, dlyCode)
        put(globWord(1'b1, 1'b0, LOCK_HIZ, REF_DIV_DEFAULT));
        foreach (rows[k]) begin
            put(outWord(rows[k].i, rows[k].p, rows[k].e, 8'h01, rows[k].y));
            `CHK("path", rows[k].p, pathSel[rows[k].i*2 +: 2])
            `CHK("delay", rows[k].p[1] ? rows[k].y : 4'h0, dlyCode[rows[k].i*4 +: 4])
            `CHK("enable", rows[k].e, ckOe[rows[k].i])
        end
        i_cop_host_model.align();
        i_cop_host_model.send(outWord(2'h0, PATH_DIVIDED, 1'b1, 8'h03, 4'h0), 32);
        `CHK("path", 2'h2, pathSel[1:0])
        i_cop_host_model.latch();
        period(0, p);
        `CHK("period", 48, p)
        put(outWord(2'h0, PATH_DIV_DLY, 1'b1, 8'hFF, 4'h3));
        period(0, p);
        `CHK("period", 4080, p)
        `CHK("delay", 4'h3, dlyCode[3:0])
        put(outWord(2'h0, PATH_BYPASS, 1'b1, 8'h03, 4'h3));
        period(0, p);
        `CHK("period", 8, p)
        `CHK("delay", 4'h0, dlyCode[3:0])
        put(globWord(1'b0, 1'b0, LOCK_HIZ, REF_DIV_DEFAULT));
        `CHK("enable", 4'h0, ckOe)
        put(globWord(1'b1, 1'b0, LOCK_HIZ, REF_DIV_DEFAULT));
        `CHK("enable", 4'h3, ckOe)
        gate = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        `CHK("enable", 4'h0, ckOe)
        `CHK("clockOut", 4'h0, ckOut)
        gate = 1'b1;
        put(globWord(1'b1, 1'b1, LOCK_HIZ, REF_DIV_DEFAULT));
        `CHK("shutdown", 1'b1, shut)
        `CHK("enable", 4'h0, ckOe)
        for (int d = 0; d < 2; d++) begin
            put(prescWord(d[0]));
            `CHK("presc", d[0], presc)
            cnt = 0;
            for (int c = 0; c < 136; c++) begin
                if (c % 4 == 0 && c < 128) ldRaw = ~ldRaw;
                prev = ldClk;
                @(posedge clock);
                #1;
                if (ldClk === 1'b1 && prev === 1'b0) cnt++;
            end
            `CHK("ldRises", d ? 4 : 16, cnt)
        end
        foreach (lk[k]) begin
            put(globWord(1'b1, 1'b0, lk[k][6:3], 12'hFFF));
            `CHK("lockOe", lk[k][2], lockOe)
            if (lk[k][1]) `CHK("lockOut", lk[k][0], lockOut)
        end
        `CHK("refDiv", 12'hFFF, refDiv)
        put(32'h8000_0000);
        `CHK("refDiv", 12'h00A, refDiv)
        `CHK("path", 8'h00, pathSel)
        // Mid-run reset must drop a live setting straight back to defaults
        put(globWord(1'b1, 1'b0, LOCK_HIGH, 12'h123));
        `CHK("lockOe", 1'b1, lockOe)
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        `CHK("refDiv", 12'h00A, refDiv)
        repeat (2) @(posedge clock);
        #1;
        `CHK("lockOe", 1'b0, lockOe)
        `CHK("refDiv", 12'h00A, refDiv)
        conclude();
    end
endmodule : tb_top
`default_nettype wire
